// ---- design/power_mode_pkg.sv ----
// Constants and carrier types for the power-mode clock control block.
// Assumes an 8-bit special function register port from the CPU core.
package power_mode_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CLOCK_MODE_ADDR   = 8'hFD;
  localparam logic [7:0] POWER_CTRL_ADDR   = 8'h87;
  localparam logic [7:0] PCLK_GATE_ADDR    = 8'hFE;
  localparam logic [7:0] PCLK_ACTIVE_ADDR  = 8'hF5;
  localparam int         LPM_ENABLE_BIT    = 2;
  localparam int         IDLE_SELECT_BIT   = 0;
  localparam int         STOP_SELECT_BIT   = 1;
  localparam logic [7:0] CLOCK_MODE_RESET  = 8'h00;
  localparam logic [7:0] PCLK_GATE_RESET   = 8'h00;
  localparam logic [7:0] PCLK_ACTIVE_RESET = 8'h00;
  localparam logic [7:0] CLOCK_MODE_MASK   = 8'h04;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam int         PERIPH_COUNT      = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_IDLE  = 4'h2,
    ST_STOP  = 4'h4,
    ST_RESET = 4'h8
  } power_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic hf_osc_en;
    logic core_reset;
  } core_ctrl_t;

endpackage : power_mode_pkg

// ---- design/clock_gate_cell.sv ----
// One peripheral clock enable with active-mode override.
// Assumes the caller registers the result.
`timescale 1ns/100ps
module clock_gate_cell
  import power_mode_pkg::*;
(
  input  wire logic i_gate_en,
  input  wire logic i_override,
  input  wire logic i_lpm,
  output logic      o_clk_en
);
  // Without low-power mode every peripheral runs outside Stop
  assign o_clk_en = !i_lpm || i_gate_en || i_override; // RQ9 RQ10
endmodule : clock_gate_cell

// ---- design/low_power_mode_clock_gating.sv ----
// Power-mode control: Stop, Idle, low-power idle and active gating.
// Assumes a single-cycle SFR port, an instruction-done strobe from the
// core, and reset request pins from outside the clock domain.
//
// Behaviour
// RQ1: Stop entered once setting instruction completes
// RQ2: Stop halts precision oscillator and CPU only; code also zeroes every peripheral clock enable in Stop
// RQ3: Only reset ends Stop; restart at zero
// RQ4: Missing clock timeout in Stop resets device
// RQ5: Software disables detector before long Stop
// RQ6: Software sets gates, enable, then Idle
// RQ7: Low-power enable gates CPU clock in Idle
// RQ8: Software sets override and gates before enable
// RQ9: Override forces peripheral clock in active mode
// RQ10: Default override leaves gate enables deciding
// RQ11: CPU always clocked in low-power active
// RQ12: Enable bit two, read/write, resets zero
// RQ13: Reserved clock mode bits read zero
// RQ14: Software may stop watchdog before Idle
// RQ15: CPU clock restored before leaving Idle
`timescale 1ns/100ps
module low_power_mode_clock_gating
  import power_mode_pkg::*;
#(
  parameter int N_PERIPH = PERIPH_COUNT
)(
  input  wire logic                i_sys_clk,
  input  wire logic                i_srst,
  input  wire logic                i_clk_en,
  input  wire sfr_req_t            i_sfr,
  input  wire logic                i_instr_done,
  input  wire logic                i_wake_irq,
  input  wire logic                i_ext_reset,
  input  wire logic                i_mcd_enable,
  input  wire logic                i_mcd_timeout,
  output logic [7:0]               o_sfr_rdata,
  output logic                     o_cpu_clk_en,
  output logic                     o_hf_osc_en,
  output logic                     o_core_reset,
  output logic [15:0]              o_start_pc,
  output logic [N_PERIPH-1:0]      o_periph_clk_en,
  output logic [3:0]               o_power_state
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic ext_rst_s1;
  logic ext_rst_s2;
  logic mcd_to_s1;
  logic mcd_to_s2;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ext_rst_s1 <= 1'b0;
      ext_rst_s2 <= 1'b0;
      mcd_to_s1  <= 1'b0;
      mcd_to_s2  <= 1'b0;
    end else if (i_clk_en) begin
      ext_rst_s1 <= i_ext_reset;
      ext_rst_s2 <= ext_rst_s1;
      mcd_to_s1  <= i_mcd_timeout;
      mcd_to_s2  <= mcd_to_s1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic                lpm_enable;
  logic                idle_req;
  logic                stop_req;
  logic [N_PERIPH-1:0] pclk_gate;
  logic [N_PERIPH-1:0] pclk_active;
  logic                reset_event;
  power_state_t        state;
  power_state_t        next_state;

  logic wr_clock_mode;
  logic wr_power_ctrl;
  assign wr_clock_mode = i_sfr.wr && (i_sfr.addr == CLOCK_MODE_ADDR);
  assign wr_power_ctrl = i_sfr.wr && (i_sfr.addr == POWER_CTRL_ADDR);

  // Detector only counts while enabled; a timeout is a reset
  assign reset_event = ext_rst_s2 || (i_mcd_enable && mcd_to_s2); // RQ4

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      lpm_enable <= CLOCK_MODE_RESET[LPM_ENABLE_BIT];
    end else if (i_clk_en && wr_clock_mode) begin
      lpm_enable <= i_sfr.wdata[LPM_ENABLE_BIT]; // RQ12
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pclk_gate   <= PCLK_GATE_RESET[N_PERIPH-1:0];
      pclk_active <= PCLK_ACTIVE_RESET[N_PERIPH-1:0];
    end else if (i_clk_en && i_sfr.wr) begin
      if (i_sfr.addr == PCLK_GATE_ADDR) begin
        pclk_gate <= i_sfr.wdata[N_PERIPH-1:0];
      end
      if (i_sfr.addr == PCLK_ACTIVE_ADDR) begin
        pclk_active <= i_sfr.wdata[N_PERIPH-1:0];
      end
    end
  end

  // Mode bits latch on write and are consumed when the instruction ends
  // Reset event waits for the clock enable like all other state
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      idle_req <= 1'b0;
      stop_req <= 1'b0;
    end else if (i_clk_en) begin
      if (reset_event) begin
        idle_req <= 1'b0; // RQ3
        stop_req <= 1'b0;
      end else if (wr_power_ctrl) begin
        idle_req <= i_sfr.wdata[IDLE_SELECT_BIT];
        stop_req <= i_sfr.wdata[STOP_SELECT_BIT];
      end else if (i_instr_done) begin
        idle_req <= 1'b0;
        stop_req <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (reset_event) begin
          next_state = ST_RESET;
        end else if (i_instr_done && stop_req) begin
          next_state = ST_STOP; // RQ1
        end else if (i_instr_done && idle_req) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (reset_event) begin
          next_state = ST_RESET;
        end else if (i_wake_irq) begin
          next_state = ST_RUN; // RQ15
        end
      end
      ST_STOP: begin
        // Interrupts cannot wake Stop
        if (reset_event) begin
          next_state = ST_RESET; // RQ3
        end
      end
      ST_RESET: begin
        if (!reset_event) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state <= ST_RUN;
    end else if (i_clk_en) begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Clock enables
  // ****************************************************************
  core_ctrl_t next_core;
  logic [N_PERIPH-1:0] next_periph;

  always_comb begin
    next_core.cpu_clk_en = 1'b1; // RQ11
    next_core.hf_osc_en  = 1'b1;
    next_core.core_reset = 1'b0;
    case (next_state)
      ST_IDLE: begin
        // Classic Idle keeps the CPU clock tree alive
        next_core.cpu_clk_en = !lpm_enable; // RQ7
      end
      ST_STOP: begin
        next_core.cpu_clk_en = 1'b0; // RQ2
        next_core.hf_osc_en  = 1'b0; // RQ2
      end
      ST_RESET: begin
        next_core.core_reset = 1'b1; // RQ3
      end
      default: begin
        next_core.cpu_clk_en = 1'b1; // RQ15
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < N_PERIPH; g++) begin : g_gate
      clock_gate_cell u_gate (
        .i_gate_en  (pclk_gate[g]),
        .i_override (pclk_active[g] && next_state == ST_RUN),
        .i_lpm      (lpm_enable),
        .o_clk_en   (next_periph[g])
      );
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_cpu_clk_en    <= 1'b1;
      o_hf_osc_en     <= 1'b1;
      o_core_reset    <= 1'b0;
      o_start_pc      <= RESET_VECTOR;
      o_periph_clk_en <= '1;
      o_power_state   <= ST_RUN;
    end else if (i_clk_en) begin
      o_cpu_clk_en    <= next_core.cpu_clk_en;
      o_hf_osc_en     <= next_core.hf_osc_en;
      o_core_reset    <= next_core.core_reset;
      o_start_pc      <= RESET_VECTOR; // RQ3
      // Nothing runs in Stop
      o_periph_clk_en <= (next_state == ST_STOP) ? '0 : next_periph;
      o_power_state   <= next_state;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_clk_en && i_sfr.rd) begin
      case (i_sfr.addr)
        CLOCK_MODE_ADDR:
          o_sfr_rdata <= {5'h00, lpm_enable, 2'h0} & CLOCK_MODE_MASK; // RQ13
        PCLK_GATE_ADDR:   o_sfr_rdata <= 8'(pclk_gate);
        PCLK_ACTIVE_ADDR: o_sfr_rdata <= 8'(pclk_active);
        POWER_CTRL_ADDR:  o_sfr_rdata <= {6'h00, stop_req, idle_req};
        default:          o_sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule : low_power_mode_clock_gating

// ---- verification/low_power_mode_clock_gating_chk.sv ----
// Checker: power-mode outputs tied to their causes at the ports.
// Assumes it is bound into the top module and sees its ports only.
`timescale 1ns/100ps
module power_mode_chk
  import power_mode_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_srst,
  input wire logic       i_clk_en,
  input wire sfr_req_t   i_sfr,
  input wire logic       i_ext_reset,
  input wire logic       i_mcd_enable,
  input wire logic       i_mcd_timeout,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_cpu_clk_en,
  input wire logic       o_hf_osc_en,
  input wire logic       o_core_reset,
  input wire logic [3:0] o_power_state
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  property p_stop_halt;
    o_power_state == ST_STOP |-> !o_cpu_clk_en && !o_hf_osc_en;
  endproperty
  a_stop_halt: assert property (p_stop_halt) else $error("stop clocks");
  property p_run_cpu;
    o_power_state == ST_RUN |-> o_cpu_clk_en && o_hf_osc_en;
  endproperty
  a_run_cpu: assert property (p_run_cpu) else $error("run clocks");
  property p_core_rst;
    o_power_state == ST_RESET |-> o_core_reset;
  endproperty
  a_core_rst: assert property (p_core_rst) else $error("core reset");
  property p_rst_exit;
    $fell(o_core_reset) |-> o_power_state == ST_RUN;
  endproperty
  a_rst_exit: assert property (p_rst_exit) else $error("reset exit");
  property p_rsv_rd;
    i_sfr.rd && i_clk_en && i_sfr.addr == CLOCK_MODE_ADDR
      |=> (o_sfr_rdata & ~CLOCK_MODE_MASK) == 8'h00;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd) else $error("reserved bits");
  property p_ext_rst;
    $rose(i_ext_reset) && i_clk_en |-> ##[1:4] o_power_state == ST_RESET;
  endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("ext reset");
  property p_mcd;
    (o_power_state == ST_STOP && i_mcd_enable && i_mcd_timeout
      && i_clk_en)[*2] |-> ##[1:3] o_power_state == ST_RESET;
  endproperty
  a_mcd: assert property (p_mcd) else $error("detector reset");
  property p_stop_stay;
    (o_power_state == ST_STOP && !i_ext_reset && !i_mcd_timeout
      && i_clk_en)[*3]
      |=> o_power_state == ST_STOP;
  endproperty
  a_stop_stay: assert property (p_stop_stay) else $error("stop left");
endmodule : power_mode_chk

bind low_power_mode_clock_gating power_mode_chk i_chk (
  .i_sys_clk, .i_srst, .i_clk_en, .i_sfr, .i_ext_reset, .i_mcd_enable,
  .i_mcd_timeout, .o_sfr_rdata, .o_cpu_clk_en, .o_hf_osc_en,
  .o_core_reset, .o_power_state
);

// ---- verification/test_low_power_mode_clock_gating.sv ----
// Bench: SFR reads and writes plus mode entry and exit sequences.
// Assumes the checker file binds itself to the design.
`timescale 1ns/100ps
module test_low_power_mode_clock_gating;
  import power_mode_pkg::*;
  logic        clk, srst, clk_en, done, wake, ext_rst, mcd_en, mcd_to;
  logic        cpu_en, osc_en, core_rst;
  logic [7:0]  rdata, pclk;
  logic [15:0] pc;
  logic [3:0]  pst;
  sfr_req_t    sfr;
  int          err_count = 0;
  int          tests_run = 0;

  low_power_mode_clock_gating #(.N_PERIPH(8)) i_dut (
    .i_sys_clk(clk), .i_srst(srst), .i_clk_en(clk_en), .i_sfr(sfr),
    .i_instr_done(done), .i_wake_irq(wake), .i_ext_reset(ext_rst),
    .i_mcd_enable(mcd_en), .i_mcd_timeout(mcd_to), .o_sfr_rdata(rdata),
    .o_cpu_clk_en(cpu_en), .o_hf_osc_en(osc_en), .o_core_reset(core_rst),
    .o_start_pc(pc), .o_periph_clk_en(pclk), .o_power_state(pst)
  );

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Idle cycle after each access keeps strobes single-driven per step
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{1'b1, 1'b0, a, d};
    step(1);
    sfr = '0;
    step(1);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    sfr = '{1'b0, 1'b1, a, 8'h00};
    step(1);
    sfr = '0;
    check(16'(rdata), 16'(exp));
    step(1);
  endtask : rd
  task await(input logic [3:0] s);
    int n;
    n = 0;
    while (pst !== s && n < 8) begin
      step(1);
      n++;
    end
    check(16'(pst), 16'(s));
    if (pst !== s) give_verdict();
  endtask : await
  task go(input logic [3:0] s);
    done = 1;
    step(1);
    done = 0;
    await(s);
  endtask : go
  task give_verdict();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    srst = 1;
    clk_en = 1;
    sfr = '0;
    done = 0;
    wake = 0;
    ext_rst = 0;
    mcd_en = 0;
    mcd_to = 0;
    step(2);
    srst = 0;
    rd(CLOCK_MODE_ADDR, CLOCK_MODE_RESET);
    check(16'(pclk), 16'h00FF);
    rd(8'h10, 8'h00);
    clk_en = 0;
    wr(CLOCK_MODE_ADDR, 8'h04);
    clk_en = 1;
    rd(CLOCK_MODE_ADDR, 8'h00);
    wr(CLOCK_MODE_ADDR, 8'h04);
    rd(CLOCK_MODE_ADDR, 8'h04);
    wr(CLOCK_MODE_ADDR, 8'h00);
    wr(PCLK_GATE_ADDR, 8'h0F);
    wr(PCLK_ACTIVE_ADDR, 8'h30);
    wr(CLOCK_MODE_ADDR, 8'h04);
    check(16'(pclk), 16'h003F);
    check(16'(cpu_en), 16'h0001);
    wr(PCLK_ACTIVE_ADDR, 8'h00);
    check(16'(pclk), 16'h000F);
    wr(POWER_CTRL_ADDR, 8'h01);
    go(ST_IDLE);
    check(16'(cpu_en), 16'h0000);
    // No wake source: Idle must hold on its own
    step(4);
    check(16'(pst), 16'(ST_IDLE));
    wake = 1;
    await(ST_RUN);
    wake = 0;
    check(16'(cpu_en), 16'h0001);
    wr(CLOCK_MODE_ADDR, 8'h00);
    wr(POWER_CTRL_ADDR, 8'h01);
    go(ST_IDLE);
    check(16'(cpu_en), 16'h0001);
    wake = 1;
    await(ST_RUN);
    wake = 0;
    wr(POWER_CTRL_ADDR, 8'h02);
    go(ST_STOP);
    check(16'(osc_en), 16'h0000);
    // Wake and an unarmed detector must both be ignored in Stop
    wake = 1;
    mcd_to = 1;
    step(6);
    check(16'(pst), 16'(ST_STOP));
    wake = 0;
    mcd_to = 0;
    ext_rst = 1;
    await(ST_RESET);
    check(16'(core_rst), 16'h0001);
    ext_rst = 0;
    await(ST_RUN);
    check(pc, RESET_VECTOR);
    mcd_en = 1;
    wr(POWER_CTRL_ADDR, 8'h02);
    go(ST_STOP);
    mcd_to = 1;
    await(ST_RESET);
    mcd_to = 0;
    await(ST_RUN);
    // Mid-run reset taken from low-power Idle
    wr(CLOCK_MODE_ADDR, 8'h04);
    wr(POWER_CTRL_ADDR, 8'h01);
    go(ST_IDLE);
    srst = 1;
    step(1);
    srst = 0;
    check(16'(pst), 16'(ST_RUN));
    check(16'(cpu_en), 16'h0001);
    check(16'(pclk), 16'h00FF);
    rd(CLOCK_MODE_ADDR, CLOCK_MODE_RESET);
    give_verdict();
  end
endmodule : test_low_power_mode_clock_gating
